// *** verilog/mrpp_params.svh ***
`ifndef MRPP_PARAMS_SVH
`define MRPP_PARAMS_SVH

// core clock period and the management clock ceiling
`define MRPP_CORE_PERIOD_NS 4
`define MRPP_MDC_MAX_KHZ 2500
// least mdc half period in ns, then in core cycles (rounded up)
`define MRPP_MDC_HALF_NS (1000000 / (2 * `MRPP_MDC_MAX_KHZ))
`define MRPP_MDC_HALF_CYC \
    ((`MRPP_MDC_HALF_NS + `MRPP_CORE_PERIOD_NS - 1) / `MRPP_CORE_PERIOD_NS)

// reduced interface: reference clock edges per dibit at 10 Mbit/s
`define MRPP_RMII_SLOW_REP 10

// symbols per byte for each data path width
`define MRPP_MII_SYMS 2
`define MRPP_RMII_SYMS 4

// management frame layout, bit indices counted from the first bit sent
`define MRPP_MG_FRAME_BITS 64
`define MRPP_MG_TA_BIT 46
`define MRPP_MG_DATA_BIT 48
`define MRPP_MG_PREAMBLE 32'hffff_ffff
`define MRPP_MG_START 2'h1
`define MRPP_MG_OP_WR 2'h1
`define MRPP_MG_OP_RD 2'h2
`define MRPP_MG_TA_WR 2'h2

`endif

// *** verilog/mrpp_pkg.sv ***
package mrpp_pkg;

    // management engine states
    typedef enum logic {
        MRPP_MG_IDLE,
        MRPP_MG_RUN
    } mrpp_mg_state_t;

    typedef logic [63:0] mrpp_mg_frame_t;

endpackage

// *** verilog/mrpp_sync.sv ***
`timescale 1ns/1ps

// two-flop level synchroniser; first stage feeds only the second
module mrpp_sync #(
    parameter int WIDTH = 1
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;

    // metastability stage then settled stage
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            meta_q <= '0;
            sync_out <= '0;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule // mrpp_sync

// *** verilog/mrpp_phy_port.sv ***
`timescale 1ns/1ps
`include "mrpp_params.svh"

module mrpp_phy_port
    import mrpp_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic rmii_mode,
    input wire logic speed_100,
    input wire logic full_duplex,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    input wire logic tx_last,
    output logic tx_ready,
    output logic tx_underrun,
    output logic rx_byte_valid,
    output logic [7:0] rx_byte,
    output logic rx_end,
    output logic rx_frame_err,
    output logic rx_status_valid,
    output logic [3:0] rx_status,
    output logic carrier_sense,
    output logic collision,
    input wire logic mgmt_start,
    input wire logic mgmt_write,
    input wire logic [4:0] mgmt_phy,
    input wire logic [4:0] mgmt_reg,
    input wire logic [15:0] mgmt_wdata,
    output logic mgmt_busy,
    output logic mgmt_done,
    output logic [15:0] mgmt_rdata,
    input wire logic mii_tx_clk,
    output logic [3:0] mii_txd,
    output logic mii_tx_en,
    input wire logic mii_rx_clk,
    input wire logic [3:0] mii_rxd,
    input wire logic mii_rx_dv,
    input wire logic mii_rx_er,
    input wire logic mii_crs,
    input wire logic mii_col,
    output logic mdc,
    input wire logic mdio_i,
    output logic mdio_o,
    output logic mdio_oe
);

    localparam logic [3:0] REP_SLOW = 4'(`MRPP_RMII_SLOW_REP - 1);
    localparam logic [2:0] SYM_MII = 3'(`MRPP_MII_SYMS);
    localparam logic [2:0] SYM_RMII = 3'(`MRPP_RMII_SYMS);
    localparam logic [6:0] HALF_LAST = 7'(`MRPP_MDC_HALF_CYC - 1);
    localparam logic [6:0] MG_END = 7'(`MRPP_MG_FRAME_BITS);
    localparam logic [6:0] MG_TA = 7'(`MRPP_MG_TA_BIT);
    localparam logic [6:0] MG_DATA = 7'(`MRPP_MG_DATA_BIT);

    logic tx_clk_q, rx_clk_q, tx_edge, rx_edge, tx_tick, rx_tick;
    logic [3:0] tx_rep_q, rx_rep_q, rep_load;
    logic [2:0] syms;
    logic [7:0] hold_q, tx_sh_q, rx_sh_d, rx_sh_q;
    logic hold_v_q, hold_last_q, tx_gap_q, tx_take;
    logic [2:0] tx_left_q, rx_cnt_q;
    logic rx_in_frame_q, rx_err_q;
    logic [1:0] crs_col_s;
    logic [6:0] div_q, bit_q;
    logic mg_fall, mg_rise, mg_wr_q;
    mrpp_mg_state_t mg_state_q;
    mrpp_mg_frame_t mg_frame_q;

    // reduced mode: one reference clock times both paths
    assign rep_load = (rmii_mode && !speed_100) ? REP_SLOW : 4'h0;
    assign syms = rmii_mode ? SYM_RMII : SYM_MII;
    assign tx_edge = mii_tx_clk && !tx_clk_q;
    assign rx_edge = (rmii_mode ? mii_tx_clk : mii_rx_clk) && !rx_clk_q;
    assign tx_tick = tx_edge && (tx_rep_q == 4'h0);
    assign rx_tick = rx_edge && (rx_rep_q == 4'h0);

    // previous clock samples and per-symbol repeat counters
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_clk_q <= 1'b0;
            rx_clk_q <= 1'b0;
            tx_rep_q <= 4'h0;
            rx_rep_q <= 4'h0;
        end else begin
            tx_clk_q <= mii_tx_clk;
            rx_clk_q <= rmii_mode ? mii_tx_clk : mii_rx_clk;
            if (tx_edge) begin
                tx_rep_q <= (tx_rep_q == 4'h0) ? rep_load : tx_rep_q - 4'h1;
            end
            if (rx_edge) begin
                if (!mii_rx_dv) begin
                    rx_rep_q <= 4'h0;
                end else begin
                    rx_rep_q <= (rx_rep_q == 4'h0) ? rep_load
                                                   : rx_rep_q - 4'h1;
                end
            end
        end
    end

    // one-byte holding stage toward the user
    assign tx_ready = !hold_v_q;
    assign tx_take = tx_tick && tx_left_q == 3'h0 && !tx_gap_q && hold_v_q;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            hold_v_q <= 1'b0;
            hold_q <= 8'h00;
            hold_last_q <= 1'b0;
        end else if (tx_valid && tx_ready) begin
            hold_v_q <= 1'b1;
            hold_q <= tx_data;
            hold_last_q <= tx_last;
        end else if (tx_take) begin
            hold_v_q <= 1'b0;
        end
    end

    // symbol serialiser, low bits first, changes only on a tx tick
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            mii_txd <= 4'h0;
            mii_tx_en <= 1'b0;
            tx_sh_q <= 8'h00;
            tx_left_q <= 3'h0;
            tx_gap_q <= 1'b0;
            tx_underrun <= 1'b0;
        end else begin
            tx_underrun <= 1'b0;
            if (tx_tick) begin
                if (tx_left_q != 3'h0) begin
                    mii_txd <= rmii_mode ? {2'h0, tx_sh_q[1:0]}
                                         : tx_sh_q[3:0];
                    tx_sh_q <= rmii_mode ? tx_sh_q >> 2 : tx_sh_q >> 4;
                    tx_left_q <= tx_left_q - 3'h1;
                    mii_tx_en <= 1'b1;
                end else if (tx_gap_q) begin
                    mii_tx_en <= 1'b0;
                    mii_txd <= 4'h0;
                    tx_gap_q <= 1'b0;
                end else if (hold_v_q) begin
                    mii_txd <= rmii_mode ? {2'h0, hold_q[1:0]}
                                         : hold_q[3:0];
                    tx_sh_q <= rmii_mode ? hold_q >> 2 : hold_q >> 4;
                    tx_left_q <= syms - 3'h1;
                    mii_tx_en <= 1'b1;
                    tx_gap_q <= hold_last_q;
                end else begin
                    tx_underrun <= mii_tx_en;
                    mii_tx_en <= 1'b0;
                    mii_txd <= 4'h0;
                end
            end
        end
    end

    // receive shift toward the bottom, low bits arrive first
    assign rx_sh_d = rmii_mode ? {mii_rxd[1:0], rx_sh_q[7:2]}
                               : {mii_rxd, rx_sh_q[7:4]};

    // receive assembly, frame end and phy status capture
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rx_sh_q <= 8'h00;
            rx_cnt_q <= 3'h0;
            rx_byte <= 8'h00;
            rx_byte_valid <= 1'b0;
            rx_in_frame_q <= 1'b0;
            rx_err_q <= 1'b0;
            rx_end <= 1'b0;
            rx_frame_err <= 1'b0;
            rx_status <= 4'h0;
            rx_status_valid <= 1'b0;
        end else begin
            rx_byte_valid <= 1'b0;
            rx_end <= 1'b0;
            rx_status_valid <= 1'b0;
            if (rx_tick && mii_rx_dv) begin
                rx_sh_q <= rx_sh_d;
                rx_in_frame_q <= 1'b1;
                if (mii_rx_er) begin
                    rx_err_q <= 1'b1;
                end
                if (rx_cnt_q == syms - 3'h1) begin
                    rx_cnt_q <= 3'h0;
                    rx_byte <= rx_sh_d;
                    rx_byte_valid <= 1'b1;
                end else begin
                    rx_cnt_q <= rx_cnt_q + 3'h1;
                end
            end else if (rx_tick) begin
                if (rx_in_frame_q) begin
                    rx_end <= 1'b1;
                    rx_frame_err <= rx_err_q;
                end
                rx_in_frame_q <= 1'b0;
                rx_err_q <= 1'b0;
                rx_cnt_q <= 3'h0;
                if (mii_rx_er) begin
                    rx_status <= mii_rxd;
                    rx_status_valid <= 1'b1;
                end
            end
        end
    end

    // carrier and collision enter the core domain through synchronisers
    mrpp_sync #(.WIDTH(2)) u_crs_col_sync (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .async_in({mii_col, mii_crs}),
        .sync_out(crs_col_s)
    );

    // masked in full duplex where they carry no meaning
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            carrier_sense <= 1'b0;
            collision <= 1'b0;
        end else begin
            carrier_sense <= crs_col_s[0] && !full_duplex;
            collision <= crs_col_s[1] && !full_duplex;
        end
    end

    // management clock divider from the core clock
    assign mg_fall = (div_q == HALF_LAST) && mdc;
    assign mg_rise = (div_q == HALF_LAST) && !mdc;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            div_q <= 7'h00;
            mdc <= 1'b0;
        end else if (div_q == HALF_LAST) begin
            div_q <= 7'h00;
            mdc <= !mdc;
        end else begin
            div_q <= div_q + 7'h01;
        end
    end

    assign mgmt_busy = (mg_state_q == MRPP_MG_RUN);

    // management frame engine: drive on falling mdc, sample on rising
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            mg_state_q <= MRPP_MG_IDLE;
            mg_frame_q <= '0;
            mg_wr_q <= 1'b0;
            bit_q <= 7'h00;
            mdio_o <= 1'b0;
            mdio_oe <= 1'b0;
            mgmt_done <= 1'b0;
            mgmt_rdata <= 16'h0000;
        end else begin
            mgmt_done <= 1'b0;
            case (mg_state_q)
                MRPP_MG_IDLE: begin
                    if (mgmt_start) begin
                        mg_frame_q <= {`MRPP_MG_PREAMBLE, `MRPP_MG_START,
                            mgmt_write ? `MRPP_MG_OP_WR : `MRPP_MG_OP_RD,
                            mgmt_phy, mgmt_reg,
                            mgmt_write ? `MRPP_MG_TA_WR : 2'h0,
                            mgmt_wdata};
                        mg_wr_q <= mgmt_write;
                        bit_q <= 7'h00;
                        mg_state_q <= MRPP_MG_RUN;
                    end
                end
                MRPP_MG_RUN: begin
                    if (mg_fall && bit_q == MG_END) begin
                        mdio_oe <= 1'b0;
                        mdio_o <= 1'b0;
                        mgmt_done <= 1'b1;
                        mg_state_q <= MRPP_MG_IDLE;
                    end else if (mg_fall) begin
                        mdio_o <= mg_frame_q[63];
                        mdio_oe <= mg_wr_q || bit_q < MG_TA;
                        mg_frame_q <= mg_frame_q << 1;
                        bit_q <= bit_q + 7'h01;
                    end
                    if (mg_rise && !mg_wr_q && bit_q > MG_DATA) begin
                        mgmt_rdata <= {mgmt_rdata[14:0], mdio_i};
                    end
                end
                default: mg_state_q <= MRPP_MG_IDLE;
            endcase
        end
    end

    // a management bit is driven one full mdc cycle
    sequence s_mdc_low;
        !mdc [*8];
    endsequence

    a_mdc_half: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        $changed(mdc) |-> $past(div_q) == 7'd49)
        else $error("mdc toggled off its half period");

    a_mdc_hold: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        $fell(mdc) |-> s_mdc_low)
        else $error("mdc low phase too short");

    a_mdio_turn: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        mgmt_busy && !mg_wr_q && bit_q > 7'd46 |-> !mdio_oe)
        else $error("mdio driven during read turnaround");

    a_mdio_edge: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        $changed(mdio_o) |-> $past(div_q) == 7'd49 && !mdc)
        else $error("mdio changed away from falling mdc");

    a_tx_on_tick: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        !tx_tick |=> $stable(mii_tx_en) && $stable(mii_txd))
        else $error("transmit pins moved off a clock tick");

    a_tx_idle_zero: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        !mii_tx_en |-> mii_txd == 4'h0)
        else $error("transmit data not quiet while idle");

    a_fd_mask: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        $past(full_duplex) |-> !carrier_sense && !collision)
        else $error("carrier or collision shown in full duplex");

    sequence s_crs_steady;
        (mii_crs && !full_duplex) [*4];
    endsequence

    a_crs_sync: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        s_crs_steady |-> carrier_sense)
        else $error("carrier sense not through in three cycles");

    a_rx_err_seen: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        rx_tick && mii_rx_dv && mii_rx_er |=> rx_err_q)
        else $error("receive error not remembered");

    a_rx_byte_dv: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        rx_byte_valid |-> $past(rx_tick && mii_rx_dv))
        else $error("receive byte without data valid");

endmodule // mrpp_phy_port

// *** sim/mrpp_phy_model.sv ***
`timescale 1ns/1ps

// behavioural phy: data clocks, receive frames, tx capture, mdio agent
module mrpp_phy_model (
    input wire logic rmii_mode,
    output logic mii_tx_clk,
    output logic mii_rx_clk,
    output logic [3:0] mii_rxd,
    output logic mii_rx_dv,
    output logic mii_rx_er,
    input wire logic [3:0] mii_txd,
    input wire logic mii_tx_en,
    input wire logic mdc,
    input wire logic mdio_o,
    input wire logic mdio_oe,
    output logic mdio_i
);
    logic [3:0] txq[$];
    logic [63:0] sh = '0;
    logic [63:0] frm = '0;
    logic [6:0] cnt = '0;
    logic is_rd = 0;
    logic phy_oe = 0;
    logic phy_d = 0;
    logic rx_busy = 0;
    logic [15:0] rd_val = 16'hc3e5;

    // tx reference: 25 MHz nibble clock or 50 MHz shared reference
    // odd offset keeps reference edges off the core clock edges
    initial begin
        mii_tx_clk = 0;
        #1;
        forever #(rmii_mode ? 10 : 20) mii_tx_clk = ~mii_tx_clk;
    end

    // receive clock made here at 25 MHz
    initial begin
        {mii_rx_clk, mii_rx_dv, mii_rx_er, mii_rxd} = '0;
        forever #20 mii_rx_clk = ~mii_rx_clk;
    end

    // idle receive data keeps changing so no stale nibble looks valid
    always @(negedge mii_rx_clk) begin
        if (!rx_busy) mii_rxd <= ~mii_rxd;
    end

    // one frame of four nibbles, low nibble first, dv spanning all
    task automatic rx_send(input logic [15:0] w, input logic er);
        rx_busy = 1;
        for (int i = 0; i < 4; i++) begin
            @(negedge mii_rx_clk);
            mii_rx_dv <= 1;
            mii_rxd <= w[4*i +: 4];
            mii_rx_er <= er && i == 2;
        end
        @(negedge mii_rx_clk);
        mii_rx_dv <= 0;
        mii_rx_er <= 0;
        rx_busy = 0;
    endtask

    // status code shown with error high and dv low
    task automatic rx_status_send(input logic [3:0] s);
        rx_busy = 1;
        @(negedge mii_rx_clk);
        mii_rxd <= s;
        mii_rx_er <= 1;
        @(negedge mii_rx_clk);
        mii_rx_er <= 0;
        rx_busy = 0;
    endtask

    // symbols taken on the rising tx clock while enabled
    always @(posedge mii_tx_clk) begin
        if (mii_tx_en)
            txq.push_back(rmii_mode ? {2'h0, mii_txd[1:0]} : mii_txd);
    end

    // wire level: mac drive, else phy drive, else pull-up
    assign mdio_i = mdio_oe ? mdio_o : (phy_oe ? phy_d : 1'b1);

    // wire captured on each rising management clock during a frame
    always @(posedge mdc) begin
        if (mdio_oe || cnt >= 46) begin
            sh <= {sh[62:0], mdio_i};
            cnt <= cnt + 1;
        end
    end

    // read data changes on the falling edge, steady at the rising one
    always @(negedge mdc) begin
        if (cnt == 46) is_rd <= sh[11:10] == 2'h2;
        phy_oe <= is_rd && cnt >= 47 && cnt < 64;
        phy_d <= cnt == 47 ? 1'b0 : rd_val[4'(63 - cnt)];
        if (cnt == 64) begin
            frm <= sh;
            cnt <= '0;
            is_rd <= 0;
        end
    end
endmodule // mrpp_phy_model

// *** sim/mrpp_phy_port_tb.sv ***
`timescale 1ns/1ps
`include "mrpp_params.svh"

// self-checking bench for the phy port
module mrpp_phy_port_tb;
    logic core_clk = 0;
    logic reset_n = 0;
    logic rmii_mode, speed_100, full_duplex, tx_valid, tx_last;
    logic [7:0] tx_data, rx_byte;
    logic tx_ready, rx_byte_valid, rx_end, rx_frame_err, rx_status_valid;
    logic [3:0] rx_status, mii_txd, mii_rxd;
    logic carrier_sense, collision, mgmt_start, mgmt_write, mgmt_done;
    logic [4:0] mgmt_phy, mgmt_reg;
    logic [15:0] mgmt_wdata, mgmt_rdata;
    logic mii_tx_clk, mii_tx_en, mii_rx_clk, mii_rx_dv, mii_rx_er;
    logic mii_crs, mii_col, mdc, mdio_i, mdio_o, mdio_oe;
    logic tx_underrun, mgmt_busy;
    int runs = 0;
    int err_count = 0;
    int checked = 0;
    int cyc = 0;
    int ends = 0;
    logic last_err;
    logic [3:0] st_seen;
    logic [7:0] rxq[$];

    always #2 core_clk = ~core_clk;

    mrpp_phy_port dut (
        .core_clk, .reset_n, .rmii_mode, .speed_100, .full_duplex,
        .tx_valid, .tx_data, .tx_last, .tx_ready, .tx_underrun,
        .rx_byte_valid, .rx_byte, .rx_end, .rx_frame_err,
        .rx_status_valid, .rx_status, .carrier_sense, .collision,
        .mgmt_start, .mgmt_write, .mgmt_phy, .mgmt_reg, .mgmt_wdata,
        .mgmt_busy, .mgmt_done, .mgmt_rdata, .mii_tx_clk, .mii_txd,
        .mii_tx_en, .mii_rx_clk, .mii_rxd, .mii_rx_dv, .mii_rx_er,
        .mii_crs, .mii_col, .mdc, .mdio_i, .mdio_o, .mdio_oe
    );

    mrpp_phy_model u_phy (
        .rmii_mode, .mii_tx_clk, .mii_rx_clk, .mii_rxd, .mii_rx_dv,
        .mii_rx_er, .mii_txd, .mii_tx_en, .mdc, .mdio_o, .mdio_oe, .mdio_i
    );

    // compare one observed value against its expectation
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic test_done;
        if (err_count == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // cycle count with a ceiling against hangs
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            err_count++;
            test_done();
        end
    end

    // receive side and transmit underrun monitor
    always @(posedge core_clk) begin
        if (rx_byte_valid) rxq.push_back(rx_byte);
        if (rx_end) ends++;
        if (rx_end) last_err = rx_frame_err;
        if (rx_status_valid) st_seen = rx_status;
        if (tx_underrun) runs++;
    end

    // offer one byte and hold it until the port takes it
    task automatic send_byte(input logic [7:0] b, input logic last);
        tx_valid <= 1;
        tx_data <= b;
        tx_last <= last;
        do @(posedge core_clk); while (!tx_ready);
    endtask

    // one frame, then the symbols on the wire compared in order
    // rep: reference edges each symbol stands on the wire
    task automatic tx_run(input logic [7:0] b[$], input int w, input int rep);
        logic [3:0] e[$];
        logic [3:0] s;
        foreach (b[i]) begin
            send_byte(b[i], i == b.size() - 1);
            for (int k = 0; k < 8; k += w) begin
                s = 4'(b[i] >> k) & 4'((1 << w) - 1);
                repeat (rep) e.push_back(s);
            end
        end
        tx_valid <= 0;
        repeat (150 * rep) @(posedge core_clk);
        chk(u_phy.txq.size(), e.size());
        foreach (e[i]) chk(u_phy.txq[i], e[i]);
        chk({mii_tx_en, mii_txd}, 5'h0);
        u_phy.txq.delete();
    endtask

    // frame left without its last byte: cut short with one underrun pulse
    task automatic t_underrun;
        chk(runs, 0);
        send_byte(8'h5a, 0);
        tx_valid <= 0;
        repeat (100) @(posedge core_clk);
        chk(runs, 1);
        chk(u_phy.txq.size(), 2);
        chk(u_phy.txq[0], 4'ha);
        chk(u_phy.txq[1], 4'h5);
        chk({mii_tx_en, mii_txd}, 5'h0);
        u_phy.txq.delete();
    endtask

    // good frame then a frame with an error, then a status code
    task automatic t_rx;
        for (int f = 0; f < 2; f++) begin
            u_phy.rx_send(16'he1a5 ^ f, f[0]);
            repeat (40) @(posedge core_clk);
            chk(rxq.size(), 2);
            chk(rxq[0], 8'ha5 ^ f);
            chk(rxq[1], 8'he1);
            chk(ends, f + 1);
            chk(last_err, f);
            rxq.delete();
        end
        u_phy.rx_status_send(4'hc);
        repeat (40) @(posedge core_clk);
        chk(st_seen, 4'hc);
        chk(rxq.size(), 0);
    endtask

    // carrier and collision through the synchroniser, masked in duplex
    task automatic t_crs;
        mii_crs <= 1;
        mii_col <= 1;
        repeat (2) @(posedge core_clk);
        chk(carrier_sense, 0);
        repeat (3) @(posedge core_clk);
        chk(carrier_sense, 1);
        chk(collision, 1);
        full_duplex <= 1;
        repeat (3) @(posedge core_clk);
        chk(carrier_sense, 0);
        chk(collision, 0);
        full_duplex <= 0;
    endtask

    // one management frame, its clock period and the wire contents
    task automatic t_mgmt(input logic wr);
        logic [63:0] e;
        int t0;
        e = {`MRPP_MG_PREAMBLE, `MRPP_MG_START, wr ? 2'h1 : 2'h2,
             5'h13, 5'h0a, 2'h2, 16'hc3e5};
        mgmt_start <= 1;
        mgmt_write <= wr;
        mgmt_phy <= 5'h13;
        mgmt_reg <= 5'h0a;
        mgmt_wdata <= 16'hc3e5;
        @(posedge core_clk);
        mgmt_start <= 0;
        @(posedge mdc);
        t0 = cyc;
        chk(mgmt_busy, 1);
        @(posedge mdc);
        chk(cyc - t0, 100);
        while (!mgmt_done) @(posedge core_clk);
        repeat (10) @(posedge core_clk);
        chk(mgmt_busy, 0);
        chk(u_phy.frm, e);
        if (!wr) chk(mgmt_rdata, 16'hc3e5);
    endtask

    // main sequence
    initial begin
        {rmii_mode, full_duplex, tx_valid, tx_last, mii_crs, mii_col} = '0;
        {mgmt_start, mgmt_write, mgmt_phy, mgmt_reg, mgmt_wdata} = '0;
        speed_100 = 1;
        tx_data = '0;
        repeat (5) @(posedge core_clk);
        reset_n <= 1;
        @(posedge core_clk);
        t_crs();
        tx_run('{8'ha5, 8'h3c, 8'h81}, 4, 1);
        tx_run('{8'h7e}, 4, 1);
        t_underrun();
        t_rx();
        t_mgmt(1);
        t_mgmt(0);
        rmii_mode <= 1;
        repeat (20) @(posedge core_clk);
        tx_run('{8'hb4, 8'h2d}, 2, 1);
        speed_100 <= 0;
        repeat (20) @(posedge core_clk);
        tx_run('{8'h96}, 2, `MRPP_RMII_SLOW_REP);
        test_done();
    end
endmodule // mrpp_phy_port_tb
